/* rtl/chg_defines.svh */
// Purpose: Offsets, field positions, reset values and scaling constants of the charger option/current registers
// Assumes: Byte-wide register access at the documented byte addresses
// Notes on behaviour
// - Latch enable set holds comparator output low once triggered; toggling releases it.
// - With throttle profile comparator enabled, status flag stays set until host reads it.
// - Undervoltage disable bit: 0 keeps protection on, 1 turns it off; resets 0.
// - Learn enable lets battery discharge and stops converter; clearing returns to adapter.
// - Adapter monitor gain bit picks 20x at 0 (reset) or 40x at 1.
// - Battery monitor gain bit picks 8x at 0 or 16x at 1 (reset).
// - Input regulation enable resets 1; device clears it on automatic disable.
// - Charge block bit 0 (reset) allows charging; 1 blocks charging.
// - Seven-bit code: high byte bits 4..0, low byte bits 7..6; binary weights.
// - Code scales by sense resistor: 128 mA steps at 5 mOhm, 64 mA at 10.
// - Charge current setting is zero after power-on reset.
// - Battery removal, adapter loss, register reset, zero voltage or watchdog clear current.
// - Listed faults and converter latch-off leave the charge current unchanged.
// - Reserved high bits 7..5 must be zero; a one marks the write invalid.
// - Reserved low bits 5..0 are ignored on write.
// - Option reserved bit 2 is read-write and resets to 1.
// - With auto-off enabled, battery-present low clears input regulation enable.
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH
`define CHG_ADDR_OPTION 8'h00
`define CHG_ADDR_RATE_LO 8'h02
`define CHG_ADDR_RATE_HI 8'h03
`define CHG_OPT_RESET 8'h0E
`define CHG_BIT_CMP_LATCH 7
`define CHG_BIT_UV_DIS 6
`define CHG_BIT_LEARN 5
`define CHG_BIT_ADPT_GAIN 4
`define CHG_BIT_BAT_GAIN 3
`define CHG_BIT_IIN_EN 1
`define CHG_BIT_BLOCK 0
`define CHG_RATE_RESET 7'h00
`define CHG_HI_RSVD_MASK 8'hE0
`define CHG_STEP_5MOHM_MA 16'h0080
`define CHG_STEP_10MOHM_MA 16'h0040
`endif

/* rtl/chg_pkg.sv */
// Purpose: Shared types of the charger option/current registers
// Assumes: Constants come from chg_defines.svh
// Notes: Types only
package chg_pkg;
   typedef logic [7:0] chg_byte_t;
   typedef logic [6:0] chg_code_t;
   typedef logic [15:0] chg_ma_t;
endpackage : chg_pkg

/* rtl/chg_comparator_latch.sv */
// Purpose: Independent comparator output with optional low latch and status flag
// Assumes: Comparator input already synchronised
// Notes: Latch released on any change of the enable bit
module chg_comparator_latch (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic cmp_level_i,
   input wire logic latch_en_i,
   input wire logic profile_en_i,
   input wire logic status_read_i,
   output logic cmp_out_o,
   output logic cmp_status_o
);
   logic latch_en_d_r;
   logic latched_r;
   logic status_r;
   logic cmp_out_r;
   wire toggle = latch_en_i ^ latch_en_d_r;
   wire trig = ~cmp_level_i;
   wire latched_nxt = toggle ? 1'b0 : (latched_r | (latch_en_i & trig));
   wire status_nxt = (profile_en_i & trig) | (status_r & ~status_read_i);
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         latch_en_d_r <= 1'b0;
         latched_r <= 1'b0;
         status_r <= 1'b0;
         cmp_out_r <= 1'b1;
      end else begin
         latch_en_d_r <= latch_en_i;
         latched_r <= latched_nxt;
         status_r <= status_nxt;
         cmp_out_r <= cmp_level_i & ~latched_nxt;
      end
   end
   assign cmp_out_o = cmp_out_r;
   assign cmp_status_o = status_r;
endmodule : chg_comparator_latch

/* rtl/chg_regs.sv */
// Purpose: Option byte and charge current registers of the charge controller
// Assumes: Byte register port from the serial-bus decoder, same clock; event pins asynchronous
// Notes: Clearing events win over a same-cycle host write
`include "chg_defines.svh"
module chg_regs (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire chg_pkg::chg_byte_t reg_addr_i,
   input wire chg_pkg::chg_byte_t reg_wdata_i,
   input wire logic auto_off_en_i,
   input wire logic throttle_cmp_en_i,
   input wire logic sense_10mohm_i,
   input wire logic battery_present_pin_i,
   input wire logic adapter_valid_i,
   input wire logic cmp_level_i,
   input wire logic reg_reset_cmd_i,
   input wire logic voltage_zero_wr_i,
   input wire logic watchdog_expired_i,
   input wire logic input_auto_disable_i,
   output chg_pkg::chg_byte_t reg_rdata_o,
   output logic write_invalid_o,
   output logic comparator_output_pin_o,
   output logic comparator_status_o,
   output logic system_undervoltage_disable_o,
   output logic learn_mode_enable_o,
   output logic converter_off_o,
   output logic adapter_monitor_gain_select_o,
   output logic battery_monitor_gain_select_o,
   output logic input_regulation_enable_o,
   output logic charge_enable_o,
   output chg_pkg::chg_code_t charge_code_o,
   output chg_pkg::chg_ma_t charge_current_ma_o
);
   import chg_pkg::*;

   function automatic chg_ma_t code_to_ma(input chg_code_t code, input logic half);
      chg_ma_t step;
      step = half ? `CHG_STEP_10MOHM_MA : `CHG_STEP_5MOHM_MA;
      code_to_ma = 16'({9'h000, code} * step);
   endfunction : code_to_ma

   // Two-flop synchronisers for pin inputs
   logic [1:0] bat_sync_r;
   logic [1:0] ac_sync_r;
   logic [1:0] cmp_sync_r;
   logic bat_prev_r;
   logic ac_prev_r;

   chg_byte_t opt_r;
   chg_byte_t opt_nxt;
   chg_code_t code_r;
   chg_code_t code_nxt;
   chg_byte_t rdata_r;
   logic invalid_r;
   logic [7:0] outs_r;
   chg_ma_t ma_r;

   wire bat_present = bat_sync_r[1];
   wire ac_valid = ac_sync_r[1];
   wire bat_fall = bat_prev_r & ~bat_present;
   wire ac_fall = ac_prev_r & ~ac_valid;
   wire wr_opt = reg_wr_i && reg_addr_i == `CHG_ADDR_OPTION;
   wire wr_lo = reg_wr_i && reg_addr_i == `CHG_ADDR_RATE_LO;
   wire wr_hi = reg_wr_i && reg_addr_i == `CHG_ADDR_RATE_HI;
   wire hi_bad = wr_hi && (reg_wdata_i & `CHG_HI_RSVD_MASK) != 8'h00;
   wire rate_clear = bat_fall | ~ac_valid | ac_fall | reg_reset_cmd_i | voltage_zero_wr_i
      | watchdog_expired_i;
   wire iin_clear = input_auto_disable_i | (auto_off_en_i & bat_fall);
   wire rd_status = reg_rd_i && reg_addr_i == `CHG_ADDR_OPTION;

   always_comb begin
      opt_nxt = opt_r;
      if (wr_opt) begin
         opt_nxt = reg_wdata_i;
      end
      if (reg_reset_cmd_i) begin
         opt_nxt = `CHG_OPT_RESET;
      end
      if (iin_clear) begin
         opt_nxt[`CHG_BIT_IIN_EN] = 1'b0;
      end
   end

   // Faults other than the listed clearing events are not inputs here, so they cannot touch the code
   always_comb begin
      code_nxt = code_r;
      if (wr_lo) begin
         code_nxt[1:0] = reg_wdata_i[7:6];
      end
      if (wr_hi && !hi_bad) begin
         code_nxt[6:2] = reg_wdata_i[4:0];
      end
      if (rate_clear) begin
         code_nxt = `CHG_RATE_RESET;
      end
   end

   chg_byte_t rd_mux;
   assign rd_mux = (reg_addr_i == `CHG_ADDR_OPTION) ? opt_r :
      (reg_addr_i == `CHG_ADDR_RATE_LO) ? {code_r[1:0], 6'h00} :
      (reg_addr_i == `CHG_ADDR_RATE_HI) ? {3'h0, code_r[6:2]} : 8'h00;

   wire [7:0] outs_nxt = {opt_nxt[`CHG_BIT_UV_DIS], opt_nxt[`CHG_BIT_LEARN],
      opt_nxt[`CHG_BIT_LEARN] & ac_valid, opt_nxt[`CHG_BIT_ADPT_GAIN], opt_nxt[`CHG_BIT_BAT_GAIN],
      opt_nxt[`CHG_BIT_IIN_EN], ~opt_nxt[`CHG_BIT_BLOCK] & ~opt_nxt[`CHG_BIT_LEARN] & ac_valid,
      1'b0};

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bat_sync_r <= 2'h0;
         ac_sync_r <= 2'h0;
         cmp_sync_r <= 2'h3;
         bat_prev_r <= 1'b0;
         ac_prev_r <= 1'b0;
      end else begin
         bat_sync_r <= {bat_sync_r[0], battery_present_pin_i};
         ac_sync_r <= {ac_sync_r[0], adapter_valid_i};
         cmp_sync_r <= {cmp_sync_r[0], cmp_level_i};
         bat_prev_r <= bat_present;
         ac_prev_r <= ac_valid;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         opt_r <= `CHG_OPT_RESET;
         code_r <= `CHG_RATE_RESET;
         ma_r <= 16'h0000;
         outs_r <= 8'h00;
      end else begin
         opt_r <= opt_nxt;
         code_r <= code_nxt;
         ma_r <= code_to_ma(code_nxt, sense_10mohm_i);
         outs_r <= outs_nxt;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= 8'h00;
         invalid_r <= 1'b0;
      end else begin
         if (reg_rd_i) begin
            rdata_r <= rd_mux;
         end
         invalid_r <= hi_bad;
      end
   end

   chg_comparator_latch u_cmp (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .cmp_level_i(cmp_sync_r[1]),
      .latch_en_i(opt_r[`CHG_BIT_CMP_LATCH]),
      .profile_en_i(throttle_cmp_en_i),
      .status_read_i(rd_status),
      .cmp_out_o(comparator_output_pin_o),
      .cmp_status_o(comparator_status_o)
   );

   assign reg_rdata_o = rdata_r;
   assign write_invalid_o = invalid_r;
   assign system_undervoltage_disable_o = outs_r[7];
   assign learn_mode_enable_o = outs_r[6];
   assign converter_off_o = outs_r[5];
   assign adapter_monitor_gain_select_o = outs_r[4];
   assign battery_monitor_gain_select_o = outs_r[3];
   assign input_regulation_enable_o = outs_r[2];
   assign charge_enable_o = outs_r[1];
   assign charge_code_o = code_r;
   assign charge_current_ma_o = ma_r;
endmodule : chg_regs

/* tb/chg_regs_asserts.sv */
// Purpose: Port-level properties of the option byte and charge rate registers
// Assumes: Strobes and clearing pulses share the system clock
// Notes: Pin-driven clearing is unseen here, so write checks wait for steady pins
module chg_regs_asserts import chg_pkg::*; (
   input wire logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, sense_10mohm_i, adapter_valid_i,
   input wire logic battery_present_pin_i, reg_reset_cmd_i, voltage_zero_wr_i, watchdog_expired_i,
   input wire logic input_auto_disable_i, write_invalid_o, input_regulation_enable_o,
   input wire logic learn_mode_enable_o, charge_enable_o,
   input wire chg_byte_t reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire chg_code_t charge_code_o,
   input wire chg_ma_t charge_current_ma_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire logic clr = reg_reset_cmd_i | voltage_zero_wr_i | watchdog_expired_i;
   sequence s_hi_wr; reg_wr_i && reg_addr_i == 8'h03; endsequence
   sequence s_good_hi; (adapter_valid_i && battery_present_pin_i) [*4] ##0 s_hi_wr
      ##0 (reg_wdata_i[7:5] == 3'h0 && !clr); endsequence
   property p_inv; s_hi_wr ##0 reg_wdata_i[7:5] != 3'h0 |=> write_invalid_o; endproperty
   a_inv: assert property (p_inv) else $error("invalid flag missing");
   property p_inv_cause; write_invalid_o |-> $past(reg_wr_i && reg_addr_i == 8'h03 && reg_wdata_i[7:5] != 3'h0);
   endproperty
   a_inv_cause: assert property (p_inv_cause) else $error("invalid flag unprompted");
   property p_hi; s_good_hi |=> charge_code_o[6:2] == $past(reg_wdata_i[4:0]); endproperty
   a_hi: assert property (p_hi) else $error("high byte not applied");
   property p_ma; $stable(charge_code_o) && $stable(sense_10mohm_i) |-> charge_current_ma_o ==
      (sense_10mohm_i ? {3'h0, charge_code_o, 6'h00} : {2'h0, charge_code_o, 7'h00}); endproperty
   a_ma: assert property (p_ma) else $error("current scaling wrong");
   property p_clr; clr |=> charge_code_o == 7'h00; endproperty
   a_clr: assert property (p_clr) else $error("code not cleared");
   property p_auto; input_auto_disable_i |=> !input_regulation_enable_o; endproperty
   a_auto: assert property (p_auto) else $error("regulation enable kept");
   property p_rd_hi; reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o == {3'h0, $past(charge_code_o[6:2])};
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("high byte readback wrong");
   property p_rd_none; reg_rd_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 8'h00; endproperty
   a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
   property p_learn; learn_mode_enable_o [*2] |-> !charge_enable_o; endproperty
   a_learn: assert property (p_learn) else $error("charging during learn");
endmodule : chg_regs_asserts
bind chg_regs chg_regs_asserts u_asserts (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .sense_10mohm_i,
   .adapter_valid_i, .battery_present_pin_i, .reg_reset_cmd_i, .voltage_zero_wr_i, .watchdog_expired_i,
   .input_auto_disable_i, .write_invalid_o, .input_regulation_enable_o, .learn_mode_enable_o,
   .charge_enable_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .charge_code_o, .charge_current_ma_o);

/* tb/chg_host_model.sv */
// Purpose: Host side of the byte register port
// Assumes: Requests start 10 ns after a rising edge
// Notes: Idle address and data show the inverse of the last value
module chg_host_model import chg_pkg::*; (
   input wire logic clk_sys_i,
   input wire chg_byte_t reg_rdata_i,
   output logic reg_wr_o = 1'b0,
   output logic reg_rd_o = 1'b0,
   output chg_byte_t reg_addr_o = 8'h55,
   output chg_byte_t reg_wdata_o = 8'hAA
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic xfer(input logic w, input chg_byte_t a, d, output chg_byte_t q);
      @(posedge clk_sys_i);
      #10;
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
      @(posedge clk_sys_i);
      #10;
      q = reg_rdata_i;
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'h0, ~a, ~d};
   endtask : xfer
endmodule : chg_host_model

/* tb/tb_top.sv */
// Purpose: Directed register-port tests of the charger option and rate logic
// Assumes: Pins change 10 ns after a rising edge
// Notes: Pin events are held at least four cycles to clear the synchronisers
module tb_top import chg_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, sense = 1'b0, bat = 1'b1, adp = 1'b1, cmp = 1'b1;
   logic rr = 1'b0, vz = 1'b0, wd = 1'b0, iad = 1'b0, wr, rd, inv, cpin, cst, uv, lrn, cof, ag, bg, iin, cen;
   logic aoff = 1'b1, thr = 1'b1;
   chg_byte_t addr, wdata, rdata, q;
   chg_code_t code;
   chg_ma_t ma;
   int fails = 0, check_count = 0, cyc = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   chg_host_model HOST (.clk_sys_i, .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
      .reg_wdata_o(wdata));
   chg_regs DUT (.clk_sys_i, .rst_n_i, .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .auto_off_en_i(aoff), .throttle_cmp_en_i(thr), .sense_10mohm_i(sense), .battery_present_pin_i(bat),
      .adapter_valid_i(adp), .cmp_level_i(cmp), .reg_reset_cmd_i(rr), .voltage_zero_wr_i(vz),
      .watchdog_expired_i(wd), .input_auto_disable_i(iad), .reg_rdata_o(rdata), .write_invalid_o(inv),
      .comparator_output_pin_o(cpin), .comparator_status_o(cst), .system_undervoltage_disable_o(uv),
      .learn_mode_enable_o(lrn), .converter_off_o(cof), .adapter_monitor_gain_select_o(ag),
      .battery_monitor_gain_select_o(bg), .input_regulation_enable_o(iin), .charge_enable_o(cen),
      .charge_code_o(code), .charge_current_ma_o(ma));
   task automatic chk(string n, logic [15:0] s, e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic wr_b(chg_byte_t a, d);
      HOST.xfer(1'b1, a, d, q);
   endtask : wr_b
   task automatic rd_b(chg_byte_t a);
      HOST.xfer(1'b0, a, 8'h00, q);
   endtask : rd_b
   task automatic step(int n);
      repeat (n) @(posedge clk_sys_i);
      #10;
   endtask : step
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         finish_test;
      end
   end
   initial begin
      step(16);
      rst_n_i = 1'b1;
      step(4);
      rd_b(8'h00); chk("option", q, 8'h0E);
      rd_b(8'h03); chk("rate hi", q, 8'h00);
      chk("ma", ma, 16'h0000);
      wr_b(8'h02, 8'hFF); wr_b(8'h03, 8'h1F);
      chk("code", code, 16'h007F);
      chk("ma", ma, 16'h3F80);
      sense = 1'b1; step(2); chk("ma", ma, 16'h1FC0);
      wr_b(8'h03, 8'hE1); chk("code", code, 16'h007F);
      wr_b(8'h02, 8'h3F); chk("code", code, 16'h007C);
      rd_b(8'h7F); chk("unmapped", q, 8'h00);
      $display("rate test done");
      for (int i = 0; i < 5; i++) begin
         wr_b(8'h03, 8'h01); chk("code", code, 16'h0004);
         {rr, vz, wd} = 3'(3'h4 >> i);
         {bat, adp} = {i != 3, i != 4};
         step(1); {rr, vz, wd} = 3'h0; step(4); {bat, adp} = 2'h3; step(4);
         chk("cleared", code, 16'h0000);
         if (i == 3) chk("auto off", iin, 16'h0000);
      end
      $display("clear test done");
      wr_b(8'h00, 8'h0E); iad = 1'b1; step(1); iad = 1'b0; step(1);
      rd_b(8'h00); chk("option", q, 8'h0C);
      wr_b(8'h00, 8'h79); rd_b(8'h00); chk("option", q, 8'h79);
      chk("flags", {uv, lrn, ag, bg, cof, cen}, 16'h003E);
      wr_b(8'h00, 8'h06); step(2); chk("flags", {uv, lrn, ag, bg, cof, cen}, 16'h0001);
      wr_b(8'h00, 8'h86); cmp = 1'b0; step(4); cmp = 1'b1; step(4);
      chk("pin", {cpin, cst}, 16'h0001);
      rd_b(8'h00); step(1); chk("status", cst, 16'h0000);
      wr_b(8'h00, 8'h06); step(4); chk("pin", cpin, 16'h0001);
      cmp = 1'b0; step(4); chk("pin", cpin, 16'h0000);
      cmp = 1'b1; step(4); chk("pin", cpin, 16'h0001);
      // Profile off: a comparator trip must leave the status flag clear
      rd_b(8'h00); thr = 1'b0; cmp = 1'b0; step(4); cmp = 1'b1; step(4);
      chk("status", cst, 16'h0000);
      // Auto-off disabled: battery removal keeps input regulation enabled
      aoff = 1'b0; bat = 1'b0; step(4); bat = 1'b1; step(4);
      chk("auto off", iin, 16'h0001);
      $display("option test done");
      finish_test;
   end
endmodule : tb_top
